// ===== core/avr_regs_pkg.sv
// register map and field layout of the receiver control bank
package avr_regs_pkg;
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PKT_W = 7;

    // register offsets
    localparam logic [7:0] OFS_TEST = 8'h56;
    localparam logic [7:0] OFS_MUTE = 8'h57;
    localparam logic [7:0] OFS_ACLK = 8'h58;
    localparam logic [7:0] OFS_LINE = 8'h59;
    localparam logic [7:0] OFS_PKT = 8'h5A;
    localparam logic [7:0] OFS_MODE = 8'h5B;
    localparam logic [7:0] OFS_CHST = 8'h5E;

    // reset values
    localparam logic [7:0] RST_TEST = 8'h0F;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // mute control fields
    localparam int MUTE_OVR_BIT = 7;
    localparam int MUTE_VAL_BIT = 6;
    localparam int MUTE_NOVID_BIT = 3;
    localparam int MUTE_NOAUD_BIT = 2;
    localparam logic [7:0] MUTE_WMASK = 8'hCC;

    // audio clock fields
    localparam int ACLK_PLLEN_BIT = 7;
    localparam int ACLK_DIV_HI = 6;
    localparam int ACLK_DIV_LO = 4;
    localparam int ACLK_NCTS_BIT = 3;
    localparam int ACLK_FS_HI = 2;
    localparam int ACLK_FS_LO = 0;

    // line and fifo control fields
    localparam int LINE_NOPU_BIT = 6;
    localparam int LINE_TERMOVR_BIT = 5;
    localparam int LINE_TERMMAN_BIT = 4;
    localparam int LINE_UFRST_BIT = 2;
    localparam int LINE_OFRST_BIT = 1;
    localparam int LINE_TRI_BIT = 0;
    localparam logic [7:0] LINE_WMASK = 8'h77;

    // status fields
    localparam int MODE_HDMI_BIT = 3;
    localparam int CHST_PCM_BIT = 1;

    // field widths for derived outputs
    localparam int DIV_W = 3;
    localparam logic [3:0] DIV_ONE = 4'h1;
    localparam logic [3:0] FS_ONE = 4'h1;
endpackage

// ===== core/avr_regs.sv
`timescale 1ns/1ps
// What this block does
// RQ1 - host writes test register with 0x0F during setup for correct operation
// RQ2 - override bit 7 replaces received mute with software mute bit 6
// RQ3 - video mute disable bit 3 keeps video flowing during mute
// RQ4 - audio mute disable bit 2 keeps audio flowing during mute
// RQ5 - audio clock bit 7 enables master clock generation by the PLL
// RQ6 - PLL divider field 6:4 divides master clock by value plus one
// RQ7 - block bit 3 stops regeneration packets updating N and CTS
// RQ8 - field 2:0 picks master clock multiple of 128 fs
// RQ9 - line control bit 6 disables the serial line pull-ups
// RQ10 - termination override bit 5 picks auto (0) or manual (1) control
// RQ11 - manual bit 4 connects termination at 0, disconnects at 1
// RQ12 - bit 2 resets the audio FIFO on underflow
// RQ13 - bit 1 resets the audio FIFO on overflow
// RQ14 - bit 0 three-states the serial data and clock lines
// RQ15 - seven sticky packet-seen bits, one per packet type, normally zero
// RQ16 - channel status mode field 7:6 reports received mode, 00 defined
// RQ17 - PCM field 5:3 code 000 means two channels, no pre-emphasis
// RQ18 - field code 001 means two channels with 50/15 us pre-emphasis
// RQ19 - channel status bit 1 is 0 for linear PCM, 1 otherwise
// RQ20 - link status bit 3 reads 0 for DVI, 1 for HDMI
// RQ21 - reset or link clock loss clears all packet-seen bits; a packet arriving in the clock-loss cycle is still set
module avr_regs #(
    parameter int PKT_W = avr_regs_pkg::PKT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [avr_regs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [avr_regs_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [avr_regs_pkg::DATA_W-1:0] regRdata,
    // receiver state, same clock domain
    input wire logic rxAvMute,
    input wire logic [PKT_W-1:0] pktSeen,
    input wire logic linkClockLost,
    input wire logic hdmiMode,
    input wire logic [avr_regs_pkg::DATA_W-1:0] chanStatusIn,
    input wire logic chanStatusValid,
    input wire logic ctsPktValid,
    input wire logic autoTermOff,
    input wire logic fifoUnderflow,
    input wire logic fifoOverflow,
    // controls toward the receiver
    output logic videoMute,
    output logic audioMute,
    output logic mclkPllEnable,
    output logic [3:0] pllDivide,
    output logic [3:0] mclkFsMultiple,
    output logic ctsUpdate,
    output logic ddcPullupEnable,
    output logic ddcSerialLinesOe,
    output logic clkTermDisconnect,
    output logic audioFifoReset
);

    // software registers
    logic [7:0] testReg_ff;
    logic [7:0] muteReg_ff;
    logic [7:0] aclkReg_ff;
    logic [7:0] lineReg_ff;
    logic [PKT_W-1:0] pktSeen_ff;
    logic [PKT_W-1:0] nxt_pktSeen;
    logic [7:0] chanStatus_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] regRdata_ff;
    logic effMute;

    // output flops
    logic videoMute_ff;
    logic audioMute_ff;
    logic mclkPllEnable_ff;
    logic [3:0] pllDivide_ff;
    logic [3:0] mclkFsMultiple_ff;
    logic ctsUpdate_ff;
    logic ddcPullupEnable_ff;
    logic ddcSerialLinesOe_ff;
    logic clkTermDisconnect_ff;
    logic audioFifoReset_ff;

    // write strobe decode shared by every writable register
    function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        hit = wr && (a == ofs);
    endfunction

    // test register, held only for read back
    always_ff @(posedge clock) begin
        if (!nrst) begin
            testReg_ff <= avr_regs_pkg::RST_TEST;
        end else if (hit(regWr, regAddr, avr_regs_pkg::OFS_TEST)) begin
            testReg_ff <= regWdata; // RQ1
        end
    end

    // mute control register, unused bits read zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            muteReg_ff <= avr_regs_pkg::RST_ZERO;
        end else if (hit(regWr, regAddr, avr_regs_pkg::OFS_MUTE)) begin
            muteReg_ff <= regWdata & avr_regs_pkg::MUTE_WMASK;
        end
    end

    // audio clock and regeneration control register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            aclkReg_ff <= avr_regs_pkg::RST_ZERO;
        end else if (hit(regWr, regAddr, avr_regs_pkg::OFS_ACLK)) begin
            aclkReg_ff <= regWdata;
        end
    end

    // serial line, termination and fifo control register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lineReg_ff <= avr_regs_pkg::RST_ZERO;
        end else if (hit(regWr, regAddr, avr_regs_pkg::OFS_LINE)) begin
            lineReg_ff <= regWdata & avr_regs_pkg::LINE_WMASK;
        end
    end

    // sticky packet flags: clock loss clears, a new arrival wins the same cycle
    always_comb begin
        nxt_pktSeen = pktSeen_ff;
        if (linkClockLost) begin
            nxt_pktSeen = '0; // RQ21
        end
        nxt_pktSeen = nxt_pktSeen | pktSeen; // RQ15
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pktSeen_ff <= '0; // RQ21
        end else begin
            pktSeen_ff <= nxt_pktSeen;
        end
    end

    // channel status byte captured whenever the receiver reports a new one
    always_ff @(posedge clock) begin
        if (!nrst) begin
            chanStatus_ff <= avr_regs_pkg::RST_ZERO;
        end else if (chanStatusValid) begin
            chanStatus_ff <= chanStatusIn; // RQ16 RQ17 RQ18 RQ19
        end
    end

    // effective mute: software value replaces received state under override
    assign effMute = muteReg_ff[avr_regs_pkg::MUTE_OVR_BIT] ?
        muteReg_ff[avr_regs_pkg::MUTE_VAL_BIT] : rxAvMute; // RQ2

    // mute outputs, each path can be excused from muting
    always_ff @(posedge clock) begin
        if (!nrst) begin
            videoMute_ff <= 1'b0;
            audioMute_ff <= 1'b0;
        end else begin
            videoMute_ff <= effMute && !muteReg_ff[avr_regs_pkg::MUTE_NOVID_BIT]; // RQ3
            audioMute_ff <= effMute && !muteReg_ff[avr_regs_pkg::MUTE_NOAUD_BIT]; // RQ4
        end
    end

    // audio master clock settings toward the PLL
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mclkPllEnable_ff <= 1'b0;
            pllDivide_ff <= avr_regs_pkg::DIV_ONE;
            mclkFsMultiple_ff <= avr_regs_pkg::FS_ONE;
        end else begin
            mclkPllEnable_ff <= aclkReg_ff[avr_regs_pkg::ACLK_PLLEN_BIT]; // RQ5
            pllDivide_ff <= {1'b0, aclkReg_ff[avr_regs_pkg::ACLK_DIV_HI:
                avr_regs_pkg::ACLK_DIV_LO]} + avr_regs_pkg::DIV_ONE; // RQ6
            mclkFsMultiple_ff <= {1'b0, aclkReg_ff[avr_regs_pkg::ACLK_FS_HI:
                avr_regs_pkg::ACLK_FS_LO]} + avr_regs_pkg::FS_ONE; // RQ8
        end
    end

    // regeneration packets write N and CTS only while not blocked
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctsUpdate_ff <= 1'b0;
        end else begin
            ctsUpdate_ff <= ctsPktValid && !aclkReg_ff[avr_regs_pkg::ACLK_NCTS_BIT]; // RQ7
        end
    end

    // serial line pull-ups and drive; enable is low while lines are driven
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ddcPullupEnable_ff <= 1'b1;
            ddcSerialLinesOe_ff <= 1'b0;
        end else begin
            ddcPullupEnable_ff <= !lineReg_ff[avr_regs_pkg::LINE_NOPU_BIT]; // RQ9
            ddcSerialLinesOe_ff <= lineReg_ff[avr_regs_pkg::LINE_TRI_BIT]; // RQ14
        end
    end

    // clock termination: automatic request or manual bit
    always_ff @(posedge clock) begin
        if (!nrst) begin
            clkTermDisconnect_ff <= 1'b0;
        end else if (lineReg_ff[avr_regs_pkg::LINE_TERMOVR_BIT]) begin
            clkTermDisconnect_ff <= lineReg_ff[avr_regs_pkg::LINE_TERMMAN_BIT]; // RQ10 RQ11
        end else begin
            clkTermDisconnect_ff <= autoTermOff; // RQ10
        end
    end

    // one-cycle fifo reset pulse on an enabled underflow or overflow
    always_ff @(posedge clock) begin
        if (!nrst) begin
            audioFifoReset_ff <= 1'b0;
        end else begin
            audioFifoReset_ff <= (fifoUnderflow && lineReg_ff[avr_regs_pkg::LINE_UFRST_BIT]) // RQ12
                || (fifoOverflow && lineReg_ff[avr_regs_pkg::LINE_OFRST_BIT]); // RQ13
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        nxt_rdata = avr_regs_pkg::RST_ZERO;
        if (regAddr == avr_regs_pkg::OFS_TEST) begin
            nxt_rdata = testReg_ff;
        end else if (regAddr == avr_regs_pkg::OFS_MUTE) begin
            nxt_rdata = muteReg_ff;
        end else if (regAddr == avr_regs_pkg::OFS_ACLK) begin
            nxt_rdata = aclkReg_ff;
        end else if (regAddr == avr_regs_pkg::OFS_LINE) begin
            nxt_rdata = lineReg_ff;
        end else if (regAddr == avr_regs_pkg::OFS_PKT) begin
            nxt_rdata[PKT_W-1:0] = pktSeen_ff; // RQ15
        end else if (regAddr == avr_regs_pkg::OFS_MODE) begin
            nxt_rdata[avr_regs_pkg::MODE_HDMI_BIT] = hdmiMode; // RQ20
        end else if (regAddr == avr_regs_pkg::OFS_CHST) begin
            nxt_rdata = chanStatus_ff; // RQ16 RQ19
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            regRdata_ff <= avr_regs_pkg::RST_ZERO;
        end else if (regRd) begin
            regRdata_ff <= nxt_rdata;
        end else begin
            regRdata_ff <= avr_regs_pkg::RST_ZERO;
        end
    end

    // outputs straight from flops
    assign regRdata = regRdata_ff;
    assign videoMute = videoMute_ff;
    assign audioMute = audioMute_ff;
    assign mclkPllEnable = mclkPllEnable_ff;
    assign pllDivide = pllDivide_ff;
    assign mclkFsMultiple = mclkFsMultiple_ff;
    assign ctsUpdate = ctsUpdate_ff;
    assign ddcPullupEnable = ddcPullupEnable_ff;
    assign ddcSerialLinesOe = ddcSerialLinesOe_ff;
    assign clkTermDisconnect = clkTermDisconnect_ff;
    assign audioFifoReset = audioFifoReset_ff;

    // override forces video mute to the software value on the next edge
    AST_MUTE_OVERRIDE: assert property (@(posedge clock) disable iff (!nrst) // RQ2
        muteReg_ff[avr_regs_pkg::MUTE_OVR_BIT] && !muteReg_ff[avr_regs_pkg::MUTE_NOVID_BIT]
        && $stable(muteReg_ff) |=> videoMute == $past(muteReg_ff[avr_regs_pkg::MUTE_VAL_BIT]))
        else $error("video mute does not follow software value");

    // video passes during mute when disabled
    AST_VIDEO_PASS: assert property (@(posedge clock) disable iff (!nrst) // RQ3
        muteReg_ff[avr_regs_pkg::MUTE_NOVID_BIT] |=> !videoMute)
        else $error("video muted although mute disabled");

    // audio follows received mute without override
    AST_AUDIO_MUTE: assert property (@(posedge clock) disable iff (!nrst) // RQ4
        !muteReg_ff[avr_regs_pkg::MUTE_OVR_BIT] && !muteReg_ff[avr_regs_pkg::MUTE_NOAUD_BIT]
        |=> audioMute == $past(rxAvMute))
        else $error("audio mute does not follow link mute");

    // divider is field plus one
    AST_PLL_DIV: assert property (@(posedge clock) disable iff (!nrst) // RQ6
        hit(regWr, regAddr, avr_regs_pkg::OFS_ACLK) ##1 !regWr [*2]
        |-> pllDivide == {1'b0, $past(regWdata[avr_regs_pkg::ACLK_DIV_HI:
            avr_regs_pkg::ACLK_DIV_LO], 2)} + avr_regs_pkg::DIV_ONE)
        else $error("pll divider mismatch");

    // blocked regeneration packets never update
    AST_CTS_BLOCK: assert property (@(posedge clock) disable iff (!nrst) // RQ7
        aclkReg_ff[avr_regs_pkg::ACLK_NCTS_BIT] |=> !ctsUpdate)
        else $error("regeneration packet written while blocked");

    // manual termination follows the manual bit
    AST_TERM_MANUAL: assert property (@(posedge clock) disable iff (!nrst) // RQ10 RQ11
        lineReg_ff[avr_regs_pkg::LINE_TERMOVR_BIT]
        |=> clkTermDisconnect == $past(lineReg_ff[avr_regs_pkg::LINE_TERMMAN_BIT]))
        else $error("manual termination not applied");

    // overflow with auto reset enabled pulses the fifo reset
    AST_FIFO_OF: assert property (@(posedge clock) disable iff (!nrst) // RQ13
        fifoOverflow && lineReg_ff[avr_regs_pkg::LINE_OFRST_BIT] |=> audioFifoReset)
        else $error("fifo not reset on overflow");

    // no auto reset when both enables are off
    AST_FIFO_QUIET: assert property (@(posedge clock) disable iff (!nrst) // RQ12
        !lineReg_ff[avr_regs_pkg::LINE_UFRST_BIT] && !lineReg_ff[avr_regs_pkg::LINE_OFRST_BIT]
        |=> !audioFifoReset)
        else $error("fifo reset without enable");

    // three-state bit drives output enable high
    AST_DDC_TRI: assert property (@(posedge clock) disable iff (!nrst) // RQ14
        lineReg_ff[avr_regs_pkg::LINE_TRI_BIT] |=> ddcSerialLinesOe)
        else $error("serial lines not three-stated");

    // packet arrival is visible in the status flag next cycle
    AST_PKT_STICKY: assert property (@(posedge clock) disable iff (!nrst) // RQ15
        pktSeen[0] |=> pktSeen_ff[0])
        else $error("packet arrival lost");

    // clock loss with no arrival clears all flags
    AST_PKT_CLEAR: assert property (@(posedge clock) disable iff (!nrst) // RQ21
        linkClockLost && pktSeen == '0 |=> pktSeen_ff == '0)
        else $error("packet flags survive clock loss");

    // mode read reports link mode one cycle after the strobe
    AST_MODE_READ: assert property (@(posedge clock) disable iff (!nrst) // RQ20
        regRd && regAddr == avr_regs_pkg::OFS_MODE |=> regRdata == {4'h0, $past(hdmiMode), 3'h0})
        else $error("mode status read wrong");

    // master clock enable follows its register bit
    AST_MCLK_ENABLE: assert property (@(posedge clock) disable iff (!nrst) // RQ5
        1'b1 |=> mclkPllEnable == $past(aclkReg_ff[avr_regs_pkg::ACLK_PLLEN_BIT]))
        else $error("master clock enable mismatch");

    // oversampling multiple is field plus one, in units of 128 fs
    AST_FS_MULT: assert property (@(posedge clock) disable iff (!nrst) // RQ8
        1'b1 |=> mclkFsMultiple == {1'b0, $past(aclkReg_ff[avr_regs_pkg::ACLK_FS_HI:
            avr_regs_pkg::ACLK_FS_LO])} + avr_regs_pkg::FS_ONE)
        else $error("master clock multiple mismatch");

    // pull-ups are dropped while the disable bit is set
    AST_PULLUP_OFF: assert property (@(posedge clock) disable iff (!nrst) // RQ9
        lineReg_ff[avr_regs_pkg::LINE_NOPU_BIT] |=> !ddcPullupEnable)
        else $error("pull-ups left on");

    // underflow with auto reset enabled pulses the fifo reset
    AST_FIFO_UF: assert property (@(posedge clock) disable iff (!nrst) // RQ12
        fifoUnderflow && lineReg_ff[avr_regs_pkg::LINE_UFRST_BIT] |=> audioFifoReset)
        else $error("fifo not reset on underflow");

    // automatic termination follows the request when not overridden
    AST_TERM_AUTO: assert property (@(posedge clock) disable iff (!nrst) // RQ10
        !lineReg_ff[avr_regs_pkg::LINE_TERMOVR_BIT] |=> clkTermDisconnect == $past(autoTermOff))
        else $error("automatic termination not applied");

endmodule // avr_regs

// ===== test/avr_src_model.sv
`timescale 1ns/1ps
// link-side source model that feeds the receiver state inputs
module avr_src_model (
    // clock
    input wire logic clock,
    // receiver state toward the register bank
    output logic rxAvMute,
    output logic [avr_regs_pkg::PKT_W-1:0] pktSeen,
    output logic linkClockLost,
    output logic hdmiMode,
    output logic [7:0] chanStatusIn,
    output logic chanStatusValid,
    output logic ctsPktValid,
    output logic autoTermOff,
    output logic fifoUnderflow,
    output logic fifoOverflow
);
    // idle levels from time zero
    initial begin
        {rxAvMute, pktSeen, linkClockLost, hdmiMode, chanStatusValid} = '0;
        {ctsPktValid, autoTermOff, fifoUnderflow, fifoOverflow} = '0;
        chanStatusIn = 8'hA5;
    end

    // one-cycle event: packet bits plus {cts, underflow, overflow, clock loss}
    task automatic pulse(input logic [avr_regs_pkg::PKT_W-1:0] pkt, input logic [3:0] ev);
        @(posedge clock);
        pktSeen <= pkt;
        {ctsPktValid, fifoUnderflow, fifoOverflow, linkClockLost} <= ev;
        @(posedge clock);
        pktSeen <= '0;
        {ctsPktValid, fifoUnderflow, fifoOverflow, linkClockLost} <= 4'h0;
        #1;
    endtask

    // channel status byte; the line is not held once the strobe drops
    task automatic sendStatus(input logic [7:0] b);
        @(posedge clock);
        chanStatusIn <= b;
        chanStatusValid <= 1'b1;
        @(posedge clock);
        chanStatusValid <= 1'b0;
        chanStatusIn <= ~b;
        #1;
    endtask

    // slow link levels, changed just after an edge
    task automatic setLevels(input logic m, input logic h, input logic t);
        @(posedge clock);
        rxAvMute <= m;
        hdmiMode <= h;
        autoTermOff <= t;
        #1;
    endtask
endmodule // avr_src_model

// ===== test/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errTotal++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} avr_row_t;
    logic clock, nrst, regWr, regRd, eff;
    logic [7:0] regAddr, regWdata, regRdata, rd, v, exp;
    logic rxAvMute, linkClockLost, hdmiMode, chanStatusValid, ctsPktValid, autoTermOff;
    logic fifoUnderflow, fifoOverflow, videoMute, audioMute, mclkPllEnable, ctsUpdate;
    logic ddcPullupEnable, ddcSerialLinesOe, clkTermDisconnect, audioFifoReset;
    logic [6:0] pktSeen;
    logic [7:0] chanStatusIn;
    logic [3:0] pllDivide, mclkFsMultiple;
    int errTotal = 0;
    int nTests = 0;
    // write, readback rows: masked, read-only and unmapped places
    avr_row_t rows [7] = '{'{8'h56, 8'h0F, 8'h0F}, '{8'h57, 8'hFF, 8'hCC},
        '{8'h58, 8'hA5, 8'hA5}, '{8'h59, 8'hFF, 8'h77}, '{8'h5A, 8'hFF, 8'h00},
        '{8'h5B, 8'hFF, 8'h00}, '{8'h5F, 8'h3C, 8'h00}};
    logic [7:0] csv [3] = '{8'h00, 8'h08, 8'h02};

    avr_regs DUT (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxAvMute(rxAvMute),
        .pktSeen(pktSeen), .linkClockLost(linkClockLost), .hdmiMode(hdmiMode),
        .chanStatusIn(chanStatusIn), .chanStatusValid(chanStatusValid),
        .ctsPktValid(ctsPktValid), .autoTermOff(autoTermOff),
        .fifoUnderflow(fifoUnderflow), .fifoOverflow(fifoOverflow), .videoMute(videoMute),
        .audioMute(audioMute), .mclkPllEnable(mclkPllEnable), .pllDivide(pllDivide),
        .mclkFsMultiple(mclkFsMultiple), .ctsUpdate(ctsUpdate),
        .ddcPullupEnable(ddcPullupEnable), .ddcSerialLinesOe(ddcSerialLinesOe),
        .clkTermDisconnect(clkTermDisconnect), .audioFifoReset(audioFifoReset));

    avr_src_model PEER (.clock(clock), .rxAvMute(rxAvMute), .pktSeen(pktSeen),
        .linkClockLost(linkClockLost), .hdmiMode(hdmiMode), .chanStatusIn(chanStatusIn),
        .chanStatusValid(chanStatusValid), .ctsPktValid(ctsPktValid),
        .autoTermOff(autoTermOff), .fifoUnderflow(fifoUnderflow),
        .fifoOverflow(fifoOverflow));

    // 100 MHz clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // register port cycles
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic resetDut(input int n);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (n) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
    endtask

    // verdict and end of run
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 600 cycles
    initial begin
        repeat (20000) @(posedge clock);
        errTotal++;
        $display("watchdog expired");
        completeRun();
    end

    // main sequence
    initial begin
        {nrst, regWr, regRd, regAddr, regWdata} = '0;
        resetDut(9);
        for (int i = 0; i < 7; i++) begin
            regRead(rows[i].a, rd);
            `CHK(rd, (i == 0) ? 8'h0F : 8'h00)
        end
        @(posedge clock);
        #1;
        `CHK(regRdata, 8'h00)
        `CHK({pllDivide, mclkFsMultiple, ddcPullupEnable, ddcSerialLinesOe}, 10'h046)
        $display("reset test done");
        // table rows
        for (int i = 0; i < 7; i++) begin
            regWrite(rows[i].a, rows[i].d);
            regRead(rows[i].a, rd);
            `CHK(rd, rows[i].e)
        end
        $display("table test done");
        // mute override and disables against the received mute
        for (int i = 0; i < 32; i++) begin
            regWrite(8'h57, {i[0], i[1], 2'b00, i[2], i[3], 2'b00});
            PEER.setLevels(i[4], 1'b0, 1'b0);
            settle();
            eff = i[0] ? i[1] : i[4];
            `CHK(videoMute, eff & !i[2])
            `CHK(audioMute, eff & !i[3])
        end
        $display("mute test done");
        // master clock enable, divider and multiple
        for (int i = 0; i < 8; i++) begin
            v = {i[0], 3'(i), 1'b0, 3'(7 - i)};
            regWrite(8'h58, v);
            settle();
            `CHK(mclkPllEnable, v[7])
            `CHK(pllDivide, 4'(i + 1))
            `CHK(mclkFsMultiple, 4'(8 - i))
        end
        regWrite(8'h58, 8'h00);
        PEER.pulse('0, 4'h8);
        `CHK(ctsUpdate, 1'b1)
        regWrite(8'h58, 8'h08);
        PEER.pulse('0, 4'h8);
        `CHK(ctsUpdate, 1'b0)
        $display("audio clock test done");
        // line pull-up, three-state and termination
        for (int i = 0; i < 32; i++) begin
            regWrite(8'h59, {1'b0, i[0], i[1], i[2], 3'b000, i[3]});
            PEER.setLevels(1'b0, 1'b0, i[4]);
            settle();
            `CHK(ddcPullupEnable, !i[0])
            `CHK(ddcSerialLinesOe, i[3])
            `CHK(clkTermDisconnect, i[1] ? i[2] : i[4])
        end
        // fifo auto reset: only the enabled event gives a pulse
        for (int i = 0; i < 4; i++) begin
            regWrite(8'h59, i[1] ? 8'h02 : 8'h04);
            PEER.pulse('0, i[0] ? 4'h2 : 4'h4);
            `CHK(audioFifoReset, i[0] == i[1])
        end
        $display("line test done");
        // sticky packet flags, cleared by clock loss
        exp = 8'h00;
        for (int i = 0; i < 7; i++) begin
            PEER.pulse(7'(1 << i), 4'h0);
            exp[i] = 1'b1;
            regRead(8'h5A, rd);
            `CHK(rd, exp)
        end
        PEER.pulse('0, 4'h1);
        regRead(8'h5A, rd);
        `CHK(rd, 8'h00)
        PEER.pulse(7'h04, 4'h1);
        regRead(8'h5A, rd);
        `CHK(rd, 8'h04)
        $display("packet test done");
        // link mode and channel status byte
        for (int i = 0; i < 2; i++) begin
            PEER.setLevels(1'b0, i[0], 1'b0);
            settle();
            regRead(8'h5B, rd);
            `CHK(rd, {4'h0, i[0], 3'h0})
        end
        for (int i = 0; i < 3; i++) begin
            PEER.sendStatus(csv[i]);
            regRead(8'h5E, rd);
            `CHK(rd, csv[i])
        end
        $display("status test done");
        // reset in mid-run clears flags and mute register, test register back to 0x0F
        PEER.pulse(7'h41, 4'h0);
        regWrite(8'h57, 8'hCC);
        resetDut(2);
        regRead(8'h5A, rd);
        `CHK(rd, 8'h00)
        regRead(8'h57, rd);
        `CHK(rd, 8'h00)
        regRead(8'h56, rd);
        `CHK(rd, 8'h0F)
        $display("second reset test done");
        completeRun();
    end
endmodule // tb
